// >>> core/smr_readout.sv
`include "smr_cfg.svh"

module smr_readout (
  input  wire logic  core_clk,
  input  wire logic  rst,
  input  wire logic  startReq,
  input  wire logic  [1:0] chanSel,
  input  wire logic  [1:0] rangeSel,
  input  wire logic  resultRead,
  input  wire logic  compIn,
  output logic [4:0] inputChannelSelect,
  output logic [9:0] dacCode,
  output logic       sampleHold,
  output logic       bandgapPwr,
  output logic       convBusy,
  output logic       convDone,
  output logic [1:0] convChan,
  output logic [9:0] rawResult,
  output logic [8:0] pressCode,
  output logic [7:0] tempCode,
  output logic [7:0] voltCode
);
  smr_conv_if cv ();

  logic        startAcc;
  logic [1:0]  chanReg;
  logic        doneReg, doneNext;
  logic [9:0]  rawReg;
  logic [8:0]  pressReg, pressNext;
  logic [7:0]  tempReg, tempNext;
  logic [7:0]  voltReg, voltNext;
  logic [10:0] pOfs;
  logic [10:0] pDiff;
  logic [10:0] pFull;
  logic        pLow, pHigh;
  logic [10:0] tFull;
  logic        tLow, tHigh;
  logic [10:0] vFull;
  logic        vLow, vHigh;
  logic        isPress, isTemp, isBgap;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Channel index to analog mux code; accel sits apart from the others.
  function automatic logic [4:0] muxCode(input logic [1:0] ch);
    case (ch)
      `SMR_CH_PRESS: muxCode = `SMR_MUX_PRESS;
      `SMR_CH_TEMP:  muxCode = `SMR_MUX_TEMP;
      `SMR_CH_BGAP:  muxCode = `SMR_MUX_BGAP;
      default:       muxCode = `SMR_MUX_ACCEL;
    endcase
  endfunction

  // Offset that places the calibrated range floor at code 1.
  function automatic logic [10:0] rangeOfs(input logic [1:0] rng);
    case (rng)
      smr_pkg::RNG_450: rangeOfs = `SMR_POFS_450;
      smr_pkg::RNG_800: rangeOfs = `SMR_POFS_800;
      default:          rangeOfs = `SMR_POFS_1500;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Converter core
  // ---------------------------------------------------------------
  smr_sar_conv u_conv (
    .core_clk   (core_clk),
    .rst        (rst),
    .cv         (cv.conv),
    .compIn     (compIn),
    .dacCode    (dacCode),
    .sampleHold (sampleHold)
  );

  // A request while busy is dropped; the requester must wait for done.
  assign startAcc = startReq && !cv.busy;
  assign cv.start = startAcc;

  // Channel routing and automatic bandgap power.
  assign inputChannelSelect = muxCode(chanReg);
  assign bandgapPwr         = cv.busy;
  assign convBusy           = cv.busy;

  // ---------------------------------------------------------------
  // Scaling of the fresh result
  // ---------------------------------------------------------------
  // Pressure: offset per calibrated range, then halve to nine bits.
  assign pOfs  = rangeOfs(rangeSel);
  // The halving copies the sign bit, so a reading under the offset
  // stays negative and is caught as below range.
  assign pDiff = {1'b0, cv.result} - pOfs;
  assign pFull = {pDiff[10], pDiff[10:1]};
  assign pLow  = pFull[10] || (pFull == 11'h000);
  assign pHigh = !pFull[10] && (pFull >= 11'(`SMR_P_HIGH));

  // Temperature: upper eight bits less an offset give Celsius plus 55.
  assign tFull = 11'({3'b000, cv.result[9:2]} - `SMR_TOFS);
  assign tLow  = tFull[10] || (tFull < `SMR_T_MIN);
  assign tHigh = !tFull[10] && (tFull > `SMR_T_MAX);

  // Voltage: a higher supply gives a smaller bandgap reading, so the
  // scaled reading is subtracted from a constant. This linear fit is
  // only good over the reportable window.
  assign vFull = 11'(`SMR_VOFS - {3'b000, cv.result[9:2]});
  assign vLow  = vFull[10] || (vFull < `SMR_V_MIN);
  assign vHigh = !vFull[10] && (vFull > `SMR_V_MAX);

  assign isPress = (chanReg == `SMR_CH_PRESS);
  assign isTemp  = (chanReg == `SMR_CH_TEMP);
  assign isBgap  = (chanReg == `SMR_CH_BGAP);

  // ---------------------------------------------------------------
  // Next values of the result registers
  // ---------------------------------------------------------------
  // Only the channel just converted updates its code; the others keep
  // their last value so the requester can read them at leisure.
  always_comb begin
    pressNext = pressReg;
    tempNext  = tempReg;
    voltNext  = voltReg;
    if (cv.done && isPress) begin
      if (pLow) begin
        pressNext = `SMR_P_LOW;
      end else if (pHigh) begin
        pressNext = `SMR_P_HIGH;
      end else begin
        pressNext = pFull[8:0];
      end
    end
    if (cv.done && isTemp) begin
      if (tLow) begin
        tempNext = `SMR_FAULT_LO8;
      end else if (tHigh) begin
        tempNext = `SMR_FAULT_HI8;
      end else begin
        tempNext = tFull[7:0];
      end
    end
    if (cv.done && isBgap) begin
      if (vLow) begin
        voltNext = `SMR_FAULT_LO8;
      end else if (vHigh) begin
        voltNext = `SMR_FAULT_HI8;
      end else begin
        voltNext = vFull[7:0];
      end
    end
  end

  // Completion flag: a finishing conversion wins over a same-cycle read.
  assign doneNext = cv.done || (doneReg && !resultRead && !startAcc);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chanReg  <= `SMR_CH_PRESS;
      doneReg  <= 1'b0;
      rawReg   <= 10'h000;
      pressReg <= `SMR_P_RESET;
      tempReg  <= `SMR_FAULT_LO8;
      voltReg  <= `SMR_FAULT_LO8;
    end else begin
      if (startAcc) chanReg <= chanSel;
      if (cv.done) rawReg <= cv.result;
      doneReg  <= doneNext;
      pressReg <= pressNext;
      tempReg  <= tempNext;
      voltReg  <= voltNext;
    end
  end

  assign convDone  = doneReg;
  assign convChan  = chanReg;
  assign rawResult = rawReg;
  assign pressCode = pressReg;
  assign tempCode  = tempReg;
  assign voltCode  = voltReg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_press_done;
    cv.done && isPress;
  endsequence
  sequence s_held;
    convDone && !resultRead && !startReq && !cv.done;
  endsequence

  a_temp_route: assert property (
    convBusy && isTemp |-> inputChannelSelect == 5'h01)
    else $error("temperature not routed to channel 1");

  a_bgap_power: assert property (
    $rose(sampleHold) |-> bandgapPwr [*8])
    else $error("bandgap unpowered during conversion");

  a_press_nofault: assert property (
    s_press_done |=> pressCode != 9'h000)
    else $error("pressure produced reserved zero code");

  a_press_clamp: assert property (
    s_press_done ##0 pLow |=> pressCode == 9'h001)
    else $error("low pressure not clamped to 001");

  a_press_scale: assert property (
    s_press_done ##0 (!pLow && !pHigh) |=> pressCode == $past(pFull[8:0]))
    else $error("pressure code not linear in result");

  a_temp_clamp: assert property (
    cv.done && isTemp && tHigh |=> tempCode == 8'hff)
    else $error("hot temperature not mapped to ff");

  a_volt_clamp: assert property (
    cv.done && isBgap && vLow |=> voltCode == 8'h00)
    else $error("low supply not mapped to 00");

  a_done_hold: assert property (
    s_held |=> convDone && $stable(rawResult))
    else $error("completion or raw result not held");

  a_done_raise: assert property (
    cv.done |=> convDone && rawResult == $past(cv.result))
    else $error("completion not raised with result");
endmodule

// >>> inc/smr_cfg.svh
`ifndef SMR_CFG_SVH
`define SMR_CFG_SVH

// ---------------------------------------------------------------
// Converter geometry and timing
// ---------------------------------------------------------------
`define SMR_RAW_W      10
`define SMR_CLK_NS     50
`define SMR_SAMPLE_NS  1000
`define SMR_SAMPLE_CYC ((`SMR_SAMPLE_NS + `SMR_CLK_NS - 1) / `SMR_CLK_NS)
`define SMR_BIT_CYC    5

// ---------------------------------------------------------------
// Channel indices and analog mux codes
// ---------------------------------------------------------------
`define SMR_CH_PRESS   2'h0
`define SMR_CH_TEMP    2'h1
`define SMR_CH_BGAP    2'h2
`define SMR_CH_ACCEL   2'h3
`define SMR_MUX_PRESS  5'h00
`define SMR_MUX_TEMP   5'h01
`define SMR_MUX_BGAP   5'h02
`define SMR_MUX_ACCEL  5'h05

// ---------------------------------------------------------------
// Scaling and clamp limits
// ---------------------------------------------------------------
`define SMR_POFS_450   11'h040
`define SMR_POFS_800   11'h030
`define SMR_POFS_1500  11'h020
`define SMR_P_LOW      9'h001
`define SMR_P_HIGH     9'h1ff
`define SMR_TOFS       11'h020
`define SMR_T_MIN      11'h00f
`define SMR_T_MAX      11'h0b4
`define SMR_VOFS       11'h12c
`define SMR_V_MIN      11'h058
`define SMR_V_MAX      11'h0ee
`define SMR_FAULT_LO8  8'h00
`define SMR_FAULT_HI8  8'hff
`define SMR_P_RESET    9'h000

`endif

// >>> inc/smr_pkg.sv
package smr_pkg;
  // Converter sequencer states.
  typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_BIT} smr_sar_state_t;
  // Calibrated pressure range choices.
  typedef enum logic [1:0] {RNG_450, RNG_800, RNG_1500} smr_range_t;
endpackage

// >>> inc/smr_conv_if.sv
// Carrier between the readout control and the converter core.
interface smr_conv_if;
  logic       start;
  logic       busy;
  logic       done;
  logic [9:0] result;
  modport ctrl (output start, input busy, input done, input result);
  modport conv (input start, output busy, output done, output result);
endinterface

// >>> core/smr_sar_conv.sv
`include "smr_cfg.svh"

module smr_sar_conv (
  input  wire logic  core_clk,
  input  wire logic  rst,
  smr_conv_if.conv   cv,
  input  wire logic  compIn,
  output logic [9:0] dacCode,
  output logic       sampleHold
);
  smr_pkg::smr_sar_state_t stateReg, stateNext;
  logic [5:0] cntReg, cntNext;
  logic [3:0] bitReg, bitNext;
  logic [9:0] trialReg, trialNext;
  logic       doneReg, doneNext;
  logic [9:0] resReg, resNext;
  logic       sync1Reg, sync2Reg, sync3Reg, compReg;
  logic       cntZero;
  logic [9:0] keptTrial;

  // ---------------------------------------------------------------
  // Comparator synchroniser
  // ---------------------------------------------------------------
  // The comparator is analog and asynchronous; a change is taken only
  // once the second and third stages agree, which filters metastability.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1Reg <= 1'b0;
      sync2Reg <= 1'b0;
      sync3Reg <= 1'b0;
      compReg  <= 1'b0;
    end else begin
      sync1Reg <= compIn;
      sync2Reg <= sync1Reg;
      sync3Reg <= sync2Reg;
      if (sync2Reg == sync3Reg) compReg <= sync3Reg;
    end
  end

  // ---------------------------------------------------------------
  // Successive approximation sequencer
  // ---------------------------------------------------------------
  assign cntZero   = (cntReg == 6'h00);
  assign keptTrial = compReg ? trialReg : (trialReg & ~(10'h001 << bitReg));

  // Each bit waits long enough for the DAC to settle and the filtered
  // comparator to follow; this costs speed but keeps every decision clean.
  always_comb begin
    stateNext = stateReg;
    cntNext   = cntZero ? cntReg : cntReg - 6'h01;
    bitNext   = bitReg;
    trialNext = trialReg;
    doneNext  = 1'b0;
    resNext   = resReg;
    case (stateReg)
      smr_pkg::SAR_IDLE: begin
        if (cv.start) begin
          stateNext = smr_pkg::SAR_SAMPLE;
          cntNext   = 6'(`SMR_SAMPLE_CYC - 1);
          trialNext = 10'h000;
        end
      end
      smr_pkg::SAR_SAMPLE: begin
        if (cntZero) begin
          stateNext = smr_pkg::SAR_BIT;
          bitNext   = 4'h9;
          trialNext = 10'h200;
          cntNext   = 6'(`SMR_BIT_CYC - 1);
        end
      end
      smr_pkg::SAR_BIT: begin
        if (cntZero) begin
          cntNext = 6'(`SMR_BIT_CYC - 1);
          if (bitReg == 4'h0) begin
            stateNext = smr_pkg::SAR_IDLE;
            resNext   = keptTrial;
            doneNext  = 1'b1;
            trialNext = keptTrial;
          end else begin
            bitNext   = bitReg - 4'h1;
            trialNext = keptTrial | (10'h001 << (bitReg - 4'h1));
          end
        end
      end
      default: stateNext = smr_pkg::SAR_IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stateReg <= smr_pkg::SAR_IDLE;
      cntReg   <= 6'h00;
      bitReg   <= 4'h0;
      trialReg <= 10'h000;
      doneReg  <= 1'b0;
      resReg   <= 10'h000;
    end else begin
      stateReg <= stateNext;
      cntReg   <= cntNext;
      bitReg   <= bitNext;
      trialReg <= trialNext;
      doneReg  <= doneNext;
      resReg   <= resNext;
    end
  end

  assign cv.busy    = (stateReg != smr_pkg::SAR_IDLE);
  assign cv.done    = doneReg;
  assign cv.result  = resReg;
  assign dacCode    = trialReg;
  assign sampleHold = (stateReg == smr_pkg::SAR_SAMPLE);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_taken;
    cv.start && !cv.busy;
  endsequence
  sequence s_sampled;
    sampleHold [*8] ##[1:30] !sampleHold;
  endsequence

  a_sar_length: assert property (
    s_taken |=> s_sampled ##[45:60] cv.done)
    else $error("conversion did not complete in expected time");
endmodule

// >>> bench/smr_source_model.sv
// ---------------------------------------------------------------
// Analog sources and comparator in front of the converter
// ---------------------------------------------------------------
module smr_source_model (
  inputChannelSelect,
  dacCode,
  levels,
  compIn
);
  timeunit 1ns;
  timeprecision 100ps;
  input  wire logic [4:0]       inputChannelSelect;
  input  wire logic [9:0]       dacCode;
  input  wire logic [3:0][9:0]  levels;
  output logic                  compIn;

  logic [9:0] selLevel;

  // Mux codes route each source; reserved codes see ground level.
  assign selLevel = (inputChannelSelect == 5'h00) ? levels[0] :
                    (inputChannelSelect == 5'h01) ? levels[1] :
                    (inputChannelSelect == 5'h02) ? levels[2] :
                    (inputChannelSelect == 5'h05) ? levels[3] :
                    10'h000;
  // Ideal comparator, so a correct search ends exactly on the level.
  assign compIn = (selLevel >= dacCode);
endmodule

// >>> bench/test_sensor_measurement_readout.sv
module test_sensor_measurement_readout;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
    errors++; $display("Error %0t: got %h expected %h", $time, got, exp); \
  end end

  logic             core_clk;
  logic             rst;
  logic             startReq;
  logic [1:0]       chanSel;
  logic [1:0]       rangeSel;
  logic             resultRead;
  logic             compIn;
  logic [3:0][9:0]  levels;
  logic [4:0]       inputChannelSelect;
  logic [9:0]       dacCode;
  logic             sampleHold;
  logic             bandgapPwr;
  logic             convBusy;
  logic             convDone;
  logic [1:0]       convChan;
  logic [9:0]       rawResult;
  logic [8:0]       pressCode;
  logic [7:0]       tempCode;
  logic [7:0]       voltCode;
  logic [8:0]       pE;
  logic [7:0]       tE;
  logic [7:0]       vE;
  int               errors;
  int               tests_run;

  smr_readout smr_readout_i (.core_clk(core_clk), .rst(rst),
    .startReq(startReq), .chanSel(chanSel), .rangeSel(rangeSel),
    .resultRead(resultRead), .compIn(compIn),
    .inputChannelSelect(inputChannelSelect), .dacCode(dacCode),
    .sampleHold(sampleHold), .bandgapPwr(bandgapPwr),
    .convBusy(convBusy), .convDone(convDone), .convChan(convChan),
    .rawResult(rawResult), .pressCode(pressCode), .tempCode(tempCode),
    .voltCode(voltCode));

  smr_source_model smr_source_model_i (
    .inputChannelSelect(inputChannelSelect), .dacCode(dacCode),
    .levels(levels), .compIn(compIn));

  // Half period of 25 ns gives the 20 MHz core clock.
  always #25 core_clk = ~core_clk;

  // ---------------------------------------------------------------
  // Expected codes, worked out independently of the design
  // ---------------------------------------------------------------
  function automatic logic [8:0] pExp(input logic [9:0] raw,
                                      input logic [1:0] rng);
    int ofs;
    int q;
    ofs = (rng == 2'h0) ? 64 : (rng == 2'h1) ? 48 : 32;
    q = (int'(raw) - ofs) / 2;
    if (q <= 0) return 9'h001;
    if (q >= 511) return 9'h1ff;
    return q[8:0];
  endfunction

  function automatic logic [7:0] clamp8(input int v, input int lo,
                                        input int hi);
    if (v < lo) return 8'h00;
    if (v > hi) return 8'hff;
    return v[7:0];
  endfunction

  task automatic complete_run;
    if (errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // One conversion; poke re-requests while busy to prove refusal
  // ---------------------------------------------------------------
  task automatic conv(input logic [1:0] ch, input logic [9:0] lvl,
                      input logic [1:0] rng, input int poke);
    int n;
    n = 0;
    @(posedge core_clk);
    for (int i = 0; i < 4; i++) begin
      levels[i] <= (i == ch) ? lvl : ~lvl;
    end
    chanSel <= ch;  // One source armed per trigger.
    rangeSel <= rng;
    @(posedge core_clk);
    startReq <= 1'b1;  // Source already settled at this point.
    @(posedge core_clk);
    startReq <= 1'b0;
    while (n < 100) begin
      @(posedge core_clk);
      n++;
      if (n == poke) begin
        startReq <= 1'b1;
        chanSel <= ~ch;
      end else if (n == poke + 1) begin
        startReq <= 1'b0;
      end
      #1;
      if (n == 1) begin
        `CHK(convBusy, 1'b1)
        `CHK(bandgapPwr, 1'b1)
        `CHK(sampleHold, 1'b1)
        `CHK(inputChannelSelect, (ch == 2'h3) ? 5'h05 : {3'h0, ch})
      end
      if (n == 19) begin
        `CHK(sampleHold, 1'b1)
      end
      if (n == 20) begin
        `CHK(sampleHold, 1'b0)
        `CHK(dacCode, 10'h200)
      end
      if (convDone === 1'b1) break;
    end
    `CHK(n, 71)
    `CHK(convBusy, 1'b0)
    `CHK(bandgapPwr, 1'b0)
    `CHK(rawResult, lvl)
    `CHK(dacCode, lvl)
    `CHK(convChan, ch)
    if (ch == 2'h0) pE = pExp(lvl, rng);
    if (ch == 2'h1) tE = clamp8(int'(lvl[9:2]) - 32, 15, 180);
    if (ch == 2'h2) vE = clamp8(300 - int'(lvl[9:2]), 88, 238);
    `CHK(pressCode, pE)
    `CHK(tempCode, tE)
    `CHK(voltCode, vE)
  endtask

  // Flag stands until read, then clears while the result stays.
  task automatic readBack(input logic [9:0] lvl);
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(convDone, 1'b1)
    @(posedge core_clk);
    resultRead <= 1'b1;
    @(posedge core_clk);
    resultRead <= 1'b0;
    #1;
    `CHK(convDone, 1'b0)
    `CHK(rawResult, lvl)
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    startReq = 1'b0;
    chanSel = 2'h0;
    rangeSel = 2'h0;
    resultRead = 1'b0;
    levels = '0;
    errors = 0;
    tests_run = 0;
    pE = 9'h000;
    tE = 8'h00;
    vE = 8'h00;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    `CHK(convDone, 1'b0)
    `CHK(pressCode, 9'h000)
    `CHK(tempCode, 8'h00)
    `CHK(voltCode, 8'h00)
    conv(2'h1, 10'h1c0, 2'h0, 0);
    conv(2'h1, 10'h0b8, 2'h0, 0);
    conv(2'h1, 10'h354, 2'h0, 0);
    conv(2'h2, 10'h258, 2'h0, 0);
    conv(2'h2, 10'h370, 2'h0, 0);
    conv(2'h2, 10'h0f0, 2'h0, 0);
    // Each pressure read takes the die as powered and trimmed.
    for (int r = 0; r < 4; r++) begin
      conv(2'h0, 10'h100, r[1:0], 0);
      conv(2'h0, 10'h3ff, r[1:0], 0);
      conv(2'h0, 10'h020, r[1:0], 0);
    end
    conv(2'h3, 10'h2a5, 2'h0, 10);
    readBack(10'h2a5);
    complete_run();
  end

  // A hung handshake ends the run well after the expected span.
  initial begin
    #200000;
    errors++;
    complete_run();
  end
endmodule
